// *** common/adcis_pkg.sv ***
package adcis_pkg;

    localparam int RES_BITS = 12;
    localparam int HI_BITS = RES_BITS - 8;
    localparam int NUM_CH_DEFAULT = 8;
    localparam int BUF_DEPTH = 2;

    // serial clock ceiling in kHz against the sampling clock
    localparam int SCL_MAX_KHZ = 3400;
    localparam int CLK_KHZ = 10000;

    // address byte layout
    localparam int ADDR_PREFIX_MSB = 7;
    localparam int ADDR_PREFIX_LSB = 3;
    localparam int ADDR_SEL_MSB = 2;
    localparam int ADDR_SEL_LSB = 1;
    localparam int ADDR_DIR_BIT = 0;
    localparam logic ADDR_DIR_READ = 1'b1;

    localparam logic INPUT_MODE_DIFF = 1'b0;
    localparam logic INPUT_MODE_SINGLE = 1'b1;

    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [1:0] STRAP_SETTLE = 2'h2;
    localparam logic [1:0] STRAP_DONE = 2'h3;

    typedef enum logic [7:0] {
        ST_IDLE     = 8'h01,
        ST_ADDR     = 8'h02,
        ST_ACK_ADDR = 8'h04,
        ST_RX       = 8'h08,
        ST_ACK_RX   = 8'h10,
        ST_TX       = 8'h20,
        ST_ACK_TX   = 8'h40,
        ST_IGNORE   = 8'h80
    } adcis_state_e;

    // command byte, most significant bit first
    typedef struct packed {
        logic       input_mode_sel;
        logic       chan_sel_bit2;
        logic       chan_sel_bit1;
        logic       chan_sel_bit0;
        logic       ref_power_bit;
        logic       conv_power_bit;
        logic [1:0] unused;
    } adcis_cmd_s;

    typedef struct packed {
        logic [2:0] pos_chan;
        logic [2:0] neg_chan;
        logic       neg_is_common;
        logic       valid;
    } adcis_mux_s;

    localparam adcis_cmd_s CMD_RESET = '0;
    localparam adcis_mux_s MUX_RESET = '0;

endpackage

// *** rtl/adcis_pair_buf.sv ***
`timescale 1ns/1ps
module adcis_pair_buf
    import adcis_pkg::*;
#(
    parameter int WIDTH = RES_BITS,
    parameter int DEPTH = BUF_DEPTH
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
            $error("buffer depth must be a power of two of at least two");
        end
    endgenerate

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
    logic [PW:0] count_reg, count_next;
    logic in_ready_reg, out_valid_reg;
    logic push, pop;

    always_comb begin
        push = in_valid & in_ready_reg;
        pop = out_ready & out_valid_reg;
        wr_ptr_next = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
        rd_ptr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
        count_next = count_reg + (PW+1)'(push) - (PW+1)'(pop);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
            in_ready_reg <= 1'b1;
            out_valid_reg <= 1'b0;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg <= count_next;
            in_ready_reg <= count_next != (PW+1)'(DEPTH);
            out_valid_reg <= count_next != '0;
        end
    end

    // storage carries no reset; validity lives in the count
    always_ff @(posedge clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    assign in_ready = in_ready_reg;
    assign out_valid = out_valid_reg;
    assign out_data = mem_reg[rd_ptr_reg];
endmodule

// *** rtl/adcis_slave.sv ***
`timescale 1ns/1ps
module adcis_slave
    import adcis_pkg::*;
#(
    parameter int NUM_CH = NUM_CH_DEFAULT,
    parameter logic [4:0] DEV_PREFIX = 5'h15 // arbitrary value
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic addr_select_hi,
    input wire logic addr_select_lo,
    input wire logic [RES_BITS-1:0] result_data,
    input wire logic result_valid,
    output logic result_ready,
    input wire logic conv_busy,
    output logic conv_start,
    output logic input_mode_sel,
    output logic [2:0] pos_chan,
    output logic [2:0] neg_chan,
    output logic neg_is_common,
    output logic chan_valid,
    output logic ref_power_on,
    output logic conv_power_on,
    output logic int_clk_en
);
    generate
        if (NUM_CH != 4 && NUM_CH != 8) begin : g_bad_ch
            $error("channel count must be 4 or 8");
        end
        // at least three samples per clock phase are needed to see edges
        if (CLK_KHZ < 6 * 100) begin : g_bad_clk
            $error("sampling clock too slow for the serial clock");
        end
    endgenerate

    // pin synchronisers: the first stage feeds only the second
    logic scl_m_reg, scl_s_reg, scl_d_reg;
    logic sda_m_reg, sda_s_reg, sda_d_reg;
    logic [1:0] strap_m_reg, strap_s_reg;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            {scl_m_reg, scl_s_reg, scl_d_reg} <= 3'h7;
            {sda_m_reg, sda_s_reg, sda_d_reg} <= 3'h7;
            {strap_m_reg, strap_s_reg} <= 4'h0;
        end else begin
            {scl_d_reg, scl_s_reg, scl_m_reg} <= {scl_s_reg, scl_m_reg, scl_in};
            {sda_d_reg, sda_s_reg, sda_m_reg} <= {sda_s_reg, sda_m_reg, sda_in};
            {strap_s_reg, strap_m_reg} <= {strap_m_reg, addr_select_hi, addr_select_lo};
        end
    end

    logic scl_rise, scl_fall, start_cond, stop_cond;

    always_comb begin
        scl_rise = scl_s_reg & ~scl_d_reg;
        scl_fall = ~scl_s_reg & scl_d_reg;
        start_cond = scl_s_reg & scl_d_reg & sda_d_reg & ~sda_s_reg;
        stop_cond = scl_s_reg & scl_d_reg & ~sda_d_reg & sda_s_reg;
    end

    // select pins caught once, after the synchroniser has filled
    logic [1:0] strap_cnt_reg, strap_cnt_next;
    logic [1:0] strap_reg, strap_next;

    always_comb begin
        strap_cnt_next = strap_cnt_reg;
        strap_next = strap_reg;
        if (strap_cnt_reg != STRAP_DONE) begin
            strap_cnt_next = strap_cnt_reg + 2'h1;
        end
        if (strap_cnt_reg == STRAP_SETTLE) begin
            strap_next = strap_s_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            {strap_cnt_reg, strap_reg} <= 4'h0;
        end else begin
            {strap_cnt_reg, strap_reg} <= {strap_cnt_next, strap_next};
        end
    end

    logic [RES_BITS-1:0] buf_data;
    logic buf_valid;
    logic buf_pop_reg, buf_pop_next;

    adcis_pair_buf #(
        .WIDTH(RES_BITS),
        .DEPTH(BUF_DEPTH)
    ) u_buf (
        .clk(clk),
        .rst_n(rst_n),
        .in_data(result_data),
        .in_valid(result_valid),
        .in_ready(result_ready),
        .out_data(buf_data),
        .out_valid(buf_valid),
        .out_ready(buf_pop_reg)
    );

    // protocol engine and command decode
    adcis_state_e state_reg, state_next;
    logic [3:0] bit_cnt_reg, bit_cnt_next;
    logic [7:0] shift_reg, shift_next;
    logic sda_oe_reg, sda_oe_next;
    logic is_read_reg, is_read_next;
    logic master_ack_reg, master_ack_next;
    logic send_lo_reg, send_lo_next;
    logic [RES_BITS-1:0] tx_word_reg, tx_word_next;
    adcis_cmd_s cmd_reg, cmd_next;
    adcis_mux_s mux_reg, mux_next;
    logic conv_start_reg, conv_start_next;
    logic ref_pending_reg, ref_pending_next;
    logic ref_on_reg, ref_on_next;
    logic conv_on_reg, conv_on_next;
    logic clk_en_reg, clk_en_next;
    logic [RES_BITS-1:0] word_pick;
    adcis_cmd_s cmd_rx;
    adcis_mux_s mux_rx;
    logic [1:0] pair;

    always_comb begin
        cmd_rx = adcis_cmd_s'(shift_reg);
        pair = {cmd_rx.chan_sel_bit1, cmd_rx.chan_sel_bit0};
        mux_rx = MUX_RESET;
        mux_rx.pos_chan = {pair, cmd_rx.chan_sel_bit2};
        if (cmd_rx.input_mode_sel == INPUT_MODE_DIFF) begin
            mux_rx.neg_chan = {pair, ~cmd_rx.chan_sel_bit2};
        end else begin
            mux_rx.neg_is_common = 1'b1;
        end
        mux_rx.valid = (NUM_CH == 8) || !cmd_rx.chan_sel_bit1;
        word_pick = buf_valid ? buf_data : tx_word_reg;
    end

    always_comb begin
        state_next = state_reg;
        bit_cnt_next = bit_cnt_reg;
        shift_next = shift_reg;
        sda_oe_next = sda_oe_reg;
        is_read_next = is_read_reg;
        master_ack_next = master_ack_reg;
        send_lo_next = send_lo_reg;
        tx_word_next = tx_word_reg;
        cmd_next = cmd_reg;
        mux_next = mux_reg;
        conv_start_next = 1'b0;
        buf_pop_next = 1'b0;
        ref_pending_next = ref_pending_reg;
        ref_on_next = ref_on_reg;
        if (start_cond || stop_cond) begin
            // both end a transfer and let a pending reference turn on
            if (ref_pending_reg) begin
                ref_on_next = 1'b1;
            end
            ref_pending_next = 1'b0;
            sda_oe_next = 1'b0;
            bit_cnt_next = 4'h0;
            state_next = start_cond ? ST_ADDR : ST_IDLE;
        end else begin
            unique case (state_reg)
                ST_IDLE, ST_IGNORE: begin
                    // wait for a start; released line
                end
                ST_ADDR, ST_RX: begin
                    if (scl_rise) begin
                        shift_next = {shift_reg[6:0], sda_s_reg};
                        bit_cnt_next = bit_cnt_reg + 4'h1;
                    end else if (scl_fall && bit_cnt_reg == BITS_PER_BYTE) begin
                        if (state_reg == ST_ADDR) begin
                            if (shift_reg[ADDR_PREFIX_MSB:ADDR_PREFIX_LSB] == DEV_PREFIX
                                && shift_reg[ADDR_SEL_MSB:ADDR_SEL_LSB] == strap_reg) begin
                                sda_oe_next = 1'b1;
                                is_read_next = shift_reg[ADDR_DIR_BIT] == ADDR_DIR_READ;
                                state_next = ST_ACK_ADDR;
                            end else begin
                                state_next = ST_IGNORE;
                            end
                        end else begin
                            sda_oe_next = 1'b1;
                            cmd_next = cmd_rx;
                            mux_next = mux_rx;
                            conv_start_next = mux_rx.valid;
                            ref_pending_next = cmd_rx.ref_power_bit;
                            if (!cmd_rx.ref_power_bit) begin
                                ref_on_next = 1'b0;
                            end
                            state_next = ST_ACK_RX;
                        end
                    end
                end
                ST_ACK_ADDR: begin
                    if (scl_fall) begin
                        bit_cnt_next = 4'h0;
                        if (is_read_reg) begin
                            tx_word_next = word_pick;
                            buf_pop_next = buf_valid;
                            shift_next = {{(8 - HI_BITS){1'b0}}, word_pick[RES_BITS-1:8]};
                            sda_oe_next = ~shift_next[7];
                            send_lo_next = 1'b1;
                            state_next = ST_TX;
                        end else begin
                            sda_oe_next = 1'b0;
                            state_next = ST_RX;
                        end
                    end
                end
                ST_ACK_RX: begin
                    if (scl_fall) begin
                        sda_oe_next = 1'b0;
                        bit_cnt_next = 4'h0;
                        state_next = ST_RX;
                    end
                end
                ST_TX: begin
                    if (scl_rise) begin
                        bit_cnt_next = bit_cnt_reg + 4'h1;
                    end else if (scl_fall) begin
                        if (bit_cnt_reg == BITS_PER_BYTE) begin
                            sda_oe_next = 1'b0;
                            state_next = ST_ACK_TX;
                        end else begin
                            shift_next = {shift_reg[6:0], 1'b0};
                            sda_oe_next = ~shift_next[7];
                        end
                    end
                end
                ST_ACK_TX: begin
                    if (scl_rise) begin
                        master_ack_next = ~sda_s_reg;
                    end else if (scl_fall) begin
                        bit_cnt_next = 4'h0;
                        if (!master_ack_reg) begin
                            sda_oe_next = 1'b0;
                            state_next = ST_IGNORE;
                        end else if (send_lo_reg) begin
                            shift_next = tx_word_reg[7:0];
                            sda_oe_next = ~shift_next[7];
                            send_lo_next = 1'b0;
                            state_next = ST_TX;
                        end else begin
                            // a further read sends the next buffered word, or repeats the last word sent when the buffer is empty
                            tx_word_next = word_pick;
                            buf_pop_next = buf_valid;
                            shift_next = {{(8 - HI_BITS){1'b0}}, word_pick[RES_BITS-1:8]};
                            sda_oe_next = ~shift_next[7];
                            send_lo_next = 1'b1;
                            state_next = ST_TX;
                        end
                    end
                end
            endcase
        end
        // core clock runs only from a start until a stop, an address miss or a read nack, or while converting
        clk_en_next = (state_next != ST_IDLE && state_next != ST_IGNORE) || conv_busy;
        conv_on_next = clk_en_next || cmd_next.conv_power_bit;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            tx_word_reg <= '0;
            cmd_reg <= CMD_RESET;
            mux_reg <= MUX_RESET;
            ref_on_reg <= 1'b0;
            {sda_oe_reg, is_read_reg, master_ack_reg, send_lo_reg, conv_start_reg} <= 5'h00;
            {buf_pop_reg, ref_pending_reg, conv_on_reg, clk_en_reg} <= 4'h0;
        end else begin
            state_reg <= state_next;
            bit_cnt_reg <= bit_cnt_next;
            shift_reg <= shift_next;
            tx_word_reg <= tx_word_next;
            cmd_reg <= cmd_next;
            mux_reg <= mux_next;
            ref_on_reg <= ref_on_next;
            {sda_oe_reg, is_read_reg, master_ack_reg} <= {sda_oe_next, is_read_next, master_ack_next};
            {send_lo_reg, conv_start_reg, buf_pop_reg} <= {send_lo_next, conv_start_next, buf_pop_next};
            {ref_pending_reg, conv_on_reg, clk_en_reg} <= {ref_pending_next, conv_on_next, clk_en_next};
        end
    end

    // open drain: only ever pull low
    logic sda_out_reg;
    always_ff @(posedge clk) begin
        sda_out_reg <= 1'b0;
    end

    assign sda_out = sda_out_reg;
    assign sda_oe = sda_oe_reg;
    assign conv_start = conv_start_reg;
    assign input_mode_sel = cmd_reg.input_mode_sel;
    assign pos_chan = mux_reg.pos_chan;
    assign neg_chan = mux_reg.neg_chan;
    assign neg_is_common = mux_reg.neg_is_common;
    assign chan_valid = mux_reg.valid;
    assign ref_power_on = ref_on_reg;
    assign conv_power_on = conv_on_reg;
    assign int_clk_en = clk_en_reg;
endmodule

// *** test/adcis_i2c_master.sv ***
`timescale 1ns/1ps
module adcis_i2c_master (
    input wire logic clk,
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    // 4 clk a phase gives the 800 ns link period
    localparam int PHASE = 4;

    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // data moves one clk after the clock falls, never while it is high
    task automatic put_bit(input logic b, output logic got);
        @(posedge clk);
        sda_low <= !b;
        repeat (PHASE - 1) @(posedge clk);
        scl <= 1'b1;
        repeat (PHASE) @(posedge clk);
        got = sda;
        scl <= 1'b0;
    endtask

    // serves as plain and as repeated start
    task automatic bus_start();
        @(posedge clk);
        sda_low <= 1'b0;
        repeat (PHASE - 1) @(posedge clk);
        scl <= 1'b1;
        repeat (PHASE) @(posedge clk);
        sda_low <= 1'b1;
        repeat (PHASE) @(posedge clk);
        scl <= 1'b0;
    endtask

    task automatic bus_stop();
        @(posedge clk);
        sda_low <= 1'b1;
        repeat (PHASE - 1) @(posedge clk);
        scl <= 1'b1;
        repeat (PHASE) @(posedge clk);
        sda_low <= 1'b0;
        repeat (PHASE) @(posedge clk);
    endtask

    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic unused;
        for (int k = 7; k >= 0; k--)
            put_bit(b[k], unused);
        put_bit(1'b1, ack);
    endtask

    // ack every byte but the last
    task automatic get_byte(input logic last, output logic [7:0] b);
        logic unused;
        for (int k = 7; k >= 0; k--)
            put_bit(1'b1, b[k]);
        put_bit(last, unused);
    endtask
endmodule

// *** test/adcis_slave_chk.sv ***
`timescale 1ns/1ps
module adcis_slave_chk
    import adcis_pkg::*;
#(
    parameter int NUM_CH = NUM_CH_DEFAULT
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic addr_select_hi,
    input wire logic addr_select_lo,
    input wire logic [RES_BITS-1:0] result_data,
    input wire logic result_valid,
    input wire logic result_ready,
    input wire logic conv_busy,
    input wire logic conv_start,
    input wire logic input_mode_sel,
    input wire logic [2:0] pos_chan,
    input wire logic [2:0] neg_chan,
    input wire logic neg_is_common,
    input wire logic chan_valid,
    input wire logic ref_power_on,
    input wire logic conv_power_on,
    input wire logic int_clk_en
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // deep in the high phase, clear of the synchroniser lag
    sequence s_scl_high;
        scl_in [*3];
    endsequence
    sequence s_busy_held;
        conv_busy [*2];
    endsequence

    property p_steady_high;
        s_scl_high |-> $stable(sda_oe);
    endproperty
    property p_drive_low;
        sda_oe |-> !sda_out;
    endproperty
    property p_start_pulse;
        conv_start |=> !conv_start;
    endproperty
    property p_start_legal;
        conv_start |=> chan_valid && (NUM_CH > 4 || !pos_chan[2]);
    endproperty
    property p_diff_pair;
        chan_valid && !input_mode_sel |-> !neg_is_common && neg_chan == {pos_chan[2:1], ~pos_chan[0]};
    endproperty
    property p_single_common;
        chan_valid && input_mode_sel |-> neg_is_common;
    endproperty
    property p_ref_at_cond;
        $rose(ref_power_on) |-> $past(scl_in, 3) && $past(scl_in, 4);
    endproperty
    property p_reset_vals;
        $rose(rst_n) |-> !ref_power_on && !sda_oe && !conv_start;
    endproperty
    property p_busy_clk;
        s_busy_held |-> int_clk_en;
    endproperty
    property p_core_power;
        int_clk_en [*2] |-> conv_power_on;
    endproperty

    a_steady_high: assert property (p_steady_high) else $error("data drive moved in clock high");
    a_drive_low: assert property (p_drive_low) else $error("data driven high");
    a_start_pulse: assert property (p_start_pulse) else $error("start pulse too long");
    a_start_legal: assert property (p_start_legal) else $error("start on illegal channel");
    a_diff_pair: assert property (p_diff_pair) else $error("bad differential pair");
    a_single_common: assert property (p_single_common) else $error("single input without common");
    a_ref_at_cond: assert property (p_ref_at_cond) else $error("reference on outside start or stop");
    a_reset_vals: assert property (p_reset_vals) else $error("bad value after reset");
    a_busy_clk: assert property (p_busy_clk) else $error("clock gated while converting");
    a_core_power: assert property (p_core_power) else $error("core unpowered while clocked");
endmodule

bind adcis_slave adcis_slave_chk #(.NUM_CH(NUM_CH)) u_chk (.*);

// *** test/tb_top.sv ***
`timescale 1ns/1ps
module tb_top
    import adcis_pkg::*;
;
    localparam logic [4:0] PFX = 5'h15; // arbitrary value
    localparam int NCH = 4;
    localparam logic [7:0] WADDR = {PFX, 2'b10, 1'b0};
    localparam logic [7:0] RADDR = {PFX, 2'b10, 1'b1};
    logic clk = 1'b0;
    logic rst_n, scl_in, sda_in, sda_low, sda_out, sda_oe, ack;
    logic addr_select_hi = 1'b1;
    logic addr_select_lo = 1'b0;
    logic [RES_BITS-1:0] result_data;
    logic result_valid, result_ready, conv_busy, conv_start, input_mode_sel;
    logic [2:0] pos_chan, neg_chan;
    logic neg_is_common, chan_valid, ref_power_on, conv_power_on, int_clk_en;
    logic [7:0] rd, cmd;
    logic [11:0] words [2] = '{12'hA5C, 12'h3F1};
    int num_errors = 0;
    int compares = 0;
    int starts = 0;
    int exp_starts = 0;

    // pulled-up wire, both parties open drain
    assign sda_in = !sda_oe && !sda_low;

    adcis_slave #(.NUM_CH(NCH), .DEV_PREFIX(PFX)) dut (.*);
    adcis_i2c_master mst (.clk(clk), .scl(scl_in), .sda_low(sda_low), .sda(sda_in));

    initial begin
        forever #50 clk = ~clk;
    end

    always @(posedge clk) begin
        if (conv_start === 1'b1)
            starts <= starts + 1;
    end

    task automatic check(input logic [11:0] got, input logic [11:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // leaves valid high so back-to-back words need no second assignment
    task automatic push(input logic [11:0] w);
        int n;
        n = 0;
        result_data <= w;
        result_valid <= 1'b1;
        @(posedge clk);
        while (result_ready !== 1'b1 && n < 50) begin
            n++;
            @(posedge clk);
        end
        if (n == 50) begin
            num_errors++;
            report_and_stop();
        end
    endtask

    initial begin
        repeat (30000) @(posedge clk);
        num_errors++;
        report_and_stop();
    end

    initial begin
        rst_n = 1'b0;
        result_valid = 1'b0;
        result_data = '0;
        conv_busy = 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        check(12'({sda_oe, ref_power_on, int_clk_en, result_ready}), 12'h001);
        conv_busy <= 1'b1;
        repeat (3) @(posedge clk);
        check(12'(int_clk_en), 12'h001);
        conv_busy <= 1'b0;
        repeat (3) @(posedge clk);
        check(12'(int_clk_en), 12'h000);
        for (int k = 0; k < 2; k++) begin
            mst.bus_start();
            mst.put_byte(k == 0 ? {PFX, 2'b01, 1'b0} : {~PFX, 2'b10, 1'b0}, ack);
            check(12'(ack), 12'h001);
            mst.put_byte(8'h8C, ack);
            check(12'(ack), 12'h001);
            mst.bus_stop();
        end
        check(12'(starts), 12'h000);
        mst.bus_start();
        mst.put_byte(WADDR, ack);
        check(12'(ack), 12'h000);
        for (int i = 0; i < 16; i++) begin
            cmd = {i[3:0], i[2:1], 2'b00};
            mst.put_byte(cmd, ack);
            check(12'(ack), 12'h000);
            if (NCH == 8 || i[1] == 1'b0) begin
                exp_starts++;
                check(12'({input_mode_sel, neg_is_common}), 12'({i[3], i[3]}));
                check(12'(pos_chan), 12'({i[1:0], i[2]}));
                if (i[3] == 1'b0)
                    check(12'(neg_chan), 12'({i[1:0], ~i[2]}));
            end
            check(12'({chan_valid, ref_power_on}), 12'({NCH == 8 || i[1] == 1'b0, 1'b0}));
            check(12'(starts), 12'(exp_starts));
        end
        mst.put_byte(8'h0C, ack);
        mst.bus_stop();
        repeat (8) @(posedge clk);
        check(12'({ref_power_on, conv_power_on, int_clk_en}), 12'h006);
        mst.bus_start();
        mst.put_byte(WADDR, ack);
        mst.put_byte(8'h04, ack);
        check(12'(ref_power_on), 12'h000);
        mst.bus_stop();
        repeat (8) @(posedge clk);
        check(12'(conv_power_on), 12'h001);
        push(words[0]);
        push(words[1]);
        result_valid <= 1'b0;
        repeat (2) @(posedge clk);
        check(12'(result_ready), 12'h000);
        mst.bus_start();
        mst.put_byte(WADDR, ack);
        mst.put_byte(8'h08, ack);
        mst.bus_start();
        repeat (6) @(posedge clk);
        check(12'(ref_power_on), 12'h001);
        mst.put_byte(RADDR, ack);
        check(12'(ack), 12'h000);
        for (int k = 0; k < 4; k++) begin
            mst.get_byte(k == 3, rd);
            check(12'(rd), k[0] ? 12'(words[k/2][7:0]) : 12'(words[k/2][11:8]));
        end
        repeat (6) @(posedge clk);
        check(12'({sda_oe, sda_in}), 12'h001);
        mst.bus_stop();
        repeat (8) @(posedge clk);
        check(12'({ref_power_on, conv_power_on, result_ready}), 12'h005);
        report_and_stop();
    end
endmodule
